// File: core/holdoff_timer.sv
// Purpose: Comparator hold-off counter.
// Assumes: Trigger is a one-cycle pulse on pclk.
// Notes: A trigger while busy is ignored; a zero length gives no hold-off.
module holdoff_timer
  import led_pulse_pkg::*;
#(
  parameter int W = HOLD_W
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic trigger,
  input wire logic [W-1:0] length,
  // Status.
  output logic busy
);

  logic [W-1:0] count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (trigger && count_reg == '0) begin
      count_reg <= length;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign busy = count_reg != '0;

endmodule : holdoff_timer

// File: core/led_link_if.sv
// Purpose: Link between the display controller end and the LED pulse device end.
// Assumes: Both ends run on the same pclk.
// Notes: Configuration flows controller to device, status flows back.
interface led_link_if;
  import led_pulse_pkg::*;

  logic [SEL_W-1:0] led_select_code;
  logic shunt_req;
  logic pulse_en;
  logic disc_mode;
  logic low_bw_sel;
  logic excess_en;
  logic [HOLD_W-1:0] holdoff_len;
  logic [LIM_W-1:0] pulse_limit [NUM_COLOURS];
  logic [THR_W-1:0] photo_threshold [NUM_GROUPS];
  logic [TIA_W-1:0] excess_threshold;
  logic photo_comparator_out;
  logic excess_flag;
  logic shunt_state;
  logic driver_state;
  logic big_cap_state;

  modport host (
    output led_select_code, shunt_req, pulse_en, disc_mode, low_bw_sel, excess_en,
    output holdoff_len, pulse_limit, photo_threshold, excess_threshold,
    input photo_comparator_out, excess_flag, shunt_state, driver_state, big_cap_state
  );

  modport dev (
    input led_select_code, shunt_req, pulse_en, disc_mode, low_bw_sel, excess_en,
    input holdoff_len, pulse_limit, photo_threshold, excess_threshold,
    output photo_comparator_out, excess_flag, shunt_state, driver_state, big_cap_state
  );
endinterface : led_link_if

// File: core/led_pulse_controller.sv
// Purpose: Controller end: APB registers that drive the link and report its status.
// Assumes: APB slave with zero wait states; pready is always high.
// Notes: Status is read-to-clear; a new event in the clearing cycle is kept.
module led_pulse_controller
  import led_pulse_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Link to the device.
  led_link_if.host link
);

  logic [3:0] ctrl_reg;
  logic [SEL_W:0] select_reg;
  logic [HOLD_W-1:0] holdoff_reg;
  logic [LIM_W-1:0] limit_reg [NUM_COLOURS];
  logic [THR_W-1:0] thresh_reg [NUM_GROUPS];
  logic [TIA_W-1:0] excess_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic comp_d_reg;
  logic excess_d_reg;
  logic wr;
  logic rd;
  logic [ST_W-1:0] events;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      select_reg <= {1'b1, SEL_OFF};
      holdoff_reg <= HOLDOFF_RESET;
      excess_reg <= EXCESS_RESET;
      mask_reg <= '0;
      for (int i = 0; i < NUM_COLOURS; i++) begin
        limit_reg[i] <= LIMIT_RESET;
      end
      for (int i = 0; i < NUM_GROUPS; i++) begin
        thresh_reg[i] <= THRESH_RESET;
      end
    end else if (wr) begin
      case (paddr)
        ADDR_CTRL: ctrl_reg <= pwdata[3:0];
        ADDR_SELECT: select_reg <= pwdata[SEL_W:0];
        ADDR_HOLDOFF: holdoff_reg <= pwdata[HOLD_W-1:0];
        ADDR_EXCESS: excess_reg <= pwdata[TIA_W-1:0];
        ADDR_MASK: mask_reg <= pwdata[ST_W-1:0];
        default: begin
          for (int i = 0; i < NUM_COLOURS; i++) begin
            if (paddr == ADDR_LIMIT0 + 8'(4 * i)) begin
              limit_reg[i] <= pwdata[LIM_W-1:0];
            end
          end
          for (int i = 0; i < NUM_GROUPS; i++) begin
            if (paddr == ADDR_THRESH0 + 8'(4 * i)) begin
              thresh_reg[i] <= pwdata[THR_W-1:0];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events and interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_d_reg <= 1'b1;
      excess_d_reg <= 1'b0;
    end else begin
      comp_d_reg <= link.photo_comparator_out;
      excess_d_reg <= link.excess_flag;
    end
  end

  assign events[ST_PULSE_DONE_BIT] = comp_d_reg && !link.photo_comparator_out;
  assign events[ST_EXCESS_BIT] = !excess_d_reg && link.excess_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else if (rd && paddr == ADDR_STATUS) begin
      status_reg <= events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.
  always_comb begin
    prdata = '0;
    case (paddr)
      ADDR_CTRL: prdata[3:0] = ctrl_reg;
      ADDR_SELECT: prdata[SEL_W:0] = select_reg;
      ADDR_HOLDOFF: prdata[HOLD_W-1:0] = holdoff_reg;
      ADDR_EXCESS: prdata[TIA_W-1:0] = excess_reg;
      ADDR_STATUS: prdata[ST_W-1:0] = status_reg;
      ADDR_MASK: prdata[ST_W-1:0] = mask_reg;
      ADDR_LEVEL: begin
        prdata[LVL_COMP_BIT] = link.photo_comparator_out;
        prdata[LVL_SHUNT_BIT] = link.shunt_state;
        prdata[LVL_DRIVER_BIT] = link.driver_state;
        prdata[LVL_EXCESS_BIT] = link.excess_flag;
        prdata[LVL_BIGCAP_BIT] = link.big_cap_state;
      end
      default: begin
        for (int i = 0; i < NUM_COLOURS; i++) begin
          if (paddr == ADDR_LIMIT0 + 8'(4 * i)) begin
            prdata[LIM_W-1:0] = limit_reg[i];
          end
        end
        for (int i = 0; i < NUM_GROUPS; i++) begin
          if (paddr == ADDR_THRESH0 + 8'(4 * i)) begin
            prdata[THR_W-1:0] = thresh_reg[i];
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link drive.
  assign link.led_select_code = select_reg[SEL_W-1:0];
  assign link.shunt_req = select_reg[SELECT_SHUNT_BIT];
  assign link.disc_mode = ctrl_reg[CTRL_DISC_BIT];
  assign link.pulse_en = ctrl_reg[CTRL_PULSE_EN_BIT];
  assign link.low_bw_sel = ctrl_reg[CTRL_LOW_BW_BIT];
  assign link.excess_en = ctrl_reg[CTRL_EXCESS_EN_BIT];
  assign link.holdoff_len = holdoff_reg;
  assign link.pulse_limit = limit_reg;
  assign link.photo_threshold = thresh_reg;
  assign link.excess_threshold = excess_reg;

endmodule : led_pulse_controller

// File: core/led_pulse_device.sv
// Purpose: Device end: select decode, pulse sequencing, hold-off filter, excess check.
// Assumes: Comparator and amplifier codes arrive from outside pclk and are synchronised.
// Notes: Link signals from the controller share pclk and are used directly.
module led_pulse_device
  import led_pulse_pkg::*;
#(
  parameter int TOGGLE_CYC = TOGGLE_OFF_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the controller.
  led_link_if.dev link,
  // Analog front end.
  input wire logic comparator_raw,
  input wire logic [TIA_W-1:0] secondary_hi_bw_code,
  input wire logic [TIA_W-1:0] secondary_lo_bw_code,
  // Driver pins.
  output logic shunt_enable_out,
  output logic driver_enable_out,
  output logic big_cap_select_out,
  output logic [THR_W-1:0] photo_dac_code
);

  typedef enum {PS_IDLE, PS_TOGGLE, PS_PULSE} pulse_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic comp_s1_reg;
  logic comp_s2_reg;
  logic comp_s3_reg;
  logic [TIA_W-1:0] hi_s1_reg;
  logic [TIA_W-1:0] hi_s2_reg;
  logic [TIA_W-1:0] lo_s1_reg;
  logic [TIA_W-1:0] lo_s2_reg;
  logic [TIA_W-1:0] hi_s3_reg;
  logic [TIA_W-1:0] lo_s3_reg;
  logic [TIA_W-1:0] hi_code_reg;
  logic [TIA_W-1:0] lo_code_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_s1_reg <= 1'b1;
      comp_s2_reg <= 1'b1;
      comp_s3_reg <= 1'b1;
    end else begin
      comp_s1_reg <= comparator_raw;
      comp_s2_reg <= comp_s1_reg;
      comp_s3_reg <= comp_s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_s1_reg <= '0;
      hi_s2_reg <= '0;
      lo_s1_reg <= '0;
      lo_s2_reg <= '0;
      hi_s3_reg <= '0;
      lo_s3_reg <= '0;
      hi_code_reg <= '0;
      lo_code_reg <= '0;
    end else begin
      hi_s1_reg <= secondary_hi_bw_code;
      hi_s2_reg <= hi_s1_reg;
      lo_s1_reg <= secondary_lo_bw_code;
      lo_s2_reg <= lo_s1_reg;
      hi_s3_reg <= hi_s2_reg;
      lo_s3_reg <= lo_s2_reg;
      if (hi_s2_reg == hi_s3_reg) begin
        hi_code_reg <= hi_s2_reg;
      end
      if (lo_s2_reg == lo_s3_reg) begin
        lo_code_reg <= lo_s2_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select decode.
  logic drv_mode;
  logic [1:0] colour;
  logic [1:0] group;

  assign drv_mode = sel_driver_on(link.led_select_code);
  assign group = sel_group(link.led_select_code);
  assign colour = drv_mode ? sel_colour(link.led_select_code)
                           : sel_group(link.led_select_code);

  ////////////////////////////////////////////////////////////////////////////////
  // Hold-off filter.
  logic comp_fall;
  logic holdoff_busy;
  logic qual_fall;
  logic comp_out_reg;

  assign comp_fall = comp_s3_reg && !comp_s2_reg;
  assign qual_fall = comp_fall && !holdoff_busy;

  holdoff_timer #(
    .W(HOLD_W)
  ) u_holdoff (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(qual_fall),
    .length(link.holdoff_len),
    .busy(holdoff_busy)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_out_reg <= 1'b1;
    end else if (qual_fall || holdoff_busy) begin
      comp_out_reg <= 1'b0;
    end else begin
      comp_out_reg <= comp_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Discontinuous pulse sequencer.
  pulse_state_t state_reg;
  pulse_state_t state_next;
  logic shunt_req_d_reg;
  logic shunt_fall;
  logic [LIM_W-1:0] run_count_reg;
  logic [LIM_W-1:0] active_limit;
  logic limit_hit;
  logic pulse_ok;

  assign shunt_fall = shunt_req_d_reg && !link.shunt_req;
  assign pulse_ok = link.disc_mode && link.pulse_en && drv_mode;
  assign active_limit = link.pulse_limit[colour - 2'd1];
  assign limit_hit = run_count_reg >= active_limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shunt_req_d_reg <= 1'b1;
    end else begin
      shunt_req_d_reg <= link.shunt_req;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_IDLE: begin
        if (pulse_ok && shunt_fall) begin
          state_next = PS_TOGGLE;
        end
      end
      PS_TOGGLE: begin
        if (!pulse_ok || link.shunt_req) begin
          state_next = PS_IDLE;
        end else if (run_count_reg >= LIM_W'(TOGGLE_CYC - 1)) begin
          state_next = PS_PULSE;
        end
      end
      PS_PULSE: begin
        if (!pulse_ok || link.shunt_req || qual_fall || limit_hit) begin
          state_next = PS_IDLE;
        end
      end
      default: begin
        state_next = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_count_reg <= '0;
    end else if (state_next != state_reg) begin
      run_count_reg <= '0;
    end else if (run_count_reg != '1) begin
      run_count_reg <= run_count_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Driver pins.
  logic shunt_next;
  logic drv_next;
  logic shunt_reg;
  logic drv_reg;
  logic big_cap_reg;
  logic [THR_W-1:0] dac_reg;

  always_comb begin
    if (!drv_mode) begin
      shunt_next = 1'b1;
      drv_next = 1'b0;
    end else if (link.disc_mode) begin
      shunt_next = state_next == PS_IDLE;
      drv_next = link.pulse_en && state_next != PS_TOGGLE;
    end else begin
      shunt_next = 1'b0;
      drv_next = link.pulse_en && !holdoff_busy && !qual_fall;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shunt_reg <= 1'b1;
      drv_reg <= 1'b0;
      big_cap_reg <= 1'b0;
      dac_reg <= '0;
    end else begin
      shunt_reg <= shunt_next;
      drv_reg <= drv_next;
      big_cap_reg <= link.disc_mode;
      dac_reg <= link.photo_threshold[group];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Excess brightness comparison.
  logic [TIA_W-1:0] secondary_code;
  logic excess_reg;

  assign secondary_code = link.low_bw_sel ? lo_code_reg : hi_code_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excess_reg <= 1'b0;
    end else begin
      excess_reg <= link.excess_en && (secondary_code > link.excess_threshold);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign shunt_enable_out = shunt_reg;
  assign driver_enable_out = drv_reg;
  assign big_cap_select_out = big_cap_reg;
  assign photo_dac_code = dac_reg;
  assign link.photo_comparator_out = comp_out_reg;
  assign link.excess_flag = excess_reg;
  assign link.shunt_state = shunt_reg;
  assign link.driver_state = drv_reg;
  assign link.big_cap_state = big_cap_reg;

endmodule : led_pulse_device

// File: core/led_pulse_pkg.sv
// Purpose: Shared constants, field layouts and decode functions for the LED pulse link.
// Assumes: One system clock pclk at 100 MHz, asynchronous active-low reset presetn.
// Notes: Register offsets are byte addresses of aligned 32-bit words on APB.
package led_pulse_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and counts.
  localparam int SEL_W = 4;
  localparam int HOLD_W = 16;
  localparam int LIM_W = 16;
  localparam int THR_W = 10;
  localparam int TIA_W = 12;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_COLOURS = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TOGGLE_OFF_NS = 50;
  localparam int TOGGLE_OFF_CYC = (TOGGLE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Select code fields and codes.
  localparam int SEL_COLOUR_LSB = 0;
  localparam int SEL_GROUP_LSB = 2;
  localparam logic [SEL_W-1:0] SEL_OFF = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SELECT = 8'h04;
  localparam logic [7:0] ADDR_HOLDOFF = 8'h08;
  localparam logic [7:0] ADDR_LIMIT0 = 8'h0C;
  localparam logic [7:0] ADDR_THRESH0 = 8'h18;
  localparam logic [7:0] ADDR_EXCESS = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_MASK = 8'h30;
  localparam logic [7:0] ADDR_LEVEL = 8'h34;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CTRL_DISC_BIT = 0;
  localparam int CTRL_PULSE_EN_BIT = 1;
  localparam int CTRL_LOW_BW_BIT = 2;
  localparam int CTRL_EXCESS_EN_BIT = 3;
  localparam int SELECT_SHUNT_BIT = 4;
  localparam int ST_PULSE_DONE_BIT = 0;
  localparam int ST_EXCESS_BIT = 1;
  localparam int ST_W = 2;
  localparam int LVL_COMP_BIT = 0;
  localparam int LVL_SHUNT_BIT = 1;
  localparam int LVL_DRIVER_BIT = 2;
  localparam int LVL_EXCESS_BIT = 3;
  localparam int LVL_BIGCAP_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [HOLD_W-1:0] HOLDOFF_RESET = 16'h0064;
  localparam logic [LIM_W-1:0] LIMIT_RESET = 16'h0100;
  localparam logic [THR_W-1:0] THRESH_RESET = 10'h000;
  localparam logic [TIA_W-1:0] EXCESS_RESET = 12'hFFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode functions.
  function automatic logic [1:0] sel_colour(input logic [SEL_W-1:0] code);
    return code[SEL_COLOUR_LSB +: 2];
  endfunction : sel_colour

  function automatic logic [1:0] sel_group(input logic [SEL_W-1:0] code);
    return code[SEL_GROUP_LSB +: 2];
  endfunction : sel_group

  function automatic logic sel_driver_on(input logic [SEL_W-1:0] code);
    return code[SEL_COLOUR_LSB +: 2] != 2'b00;
  endfunction : sel_driver_on

endpackage : led_pulse_pkg

// File: tb/led_pulse_select_control_tb.sv
// Purpose: Self-checking bench for the controller and device joined by the link.
// Assumes: pclk at 100 MHz; presetn held low for 8 cycles.
// Notes: Random values come from a 16-bit shift register started at 58578.
module led_pulse_select_control_tb
  import led_pulse_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
  `define WAITC(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(posedge pclk); n++; end end

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, comparator_raw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [TIA_W-1:0] hi_code, lo_code, t, t1;
  logic shunt_enable_out, driver_enable_out, big_cap_select_out;
  logic [THR_W-1:0] photo_dac_code;
  logic [THR_W-1:0] thr [NUM_GROUPS];
  logic [SEL_W-1:0] code;
  logic [15:0] seed = 16'hE4D2;
  int num_errors = 0, comparisons = 0, cycles = 0, n, i;

  led_link_if u_led_link_if ();
  led_pulse_controller u_led_pulse_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(u_led_link_if.host));
  led_pulse_device u_led_pulse_device (.pclk(pclk), .presetn(presetn),
    .link(u_led_link_if.dev), .comparator_raw(comparator_raw),
    .secondary_hi_bw_code(hi_code), .secondary_lo_bw_code(lo_code),
    .shunt_enable_out(shunt_enable_out), .driver_enable_out(driver_enable_out),
    .big_cap_select_out(big_cap_select_out), .photo_dac_code(photo_dac_code));
  led_pulse_sva u_led_pulse_sva (.pclk(pclk), .presetn(presetn),
    .led_select_code(u_led_link_if.led_select_code), .shunt_req(u_led_link_if.shunt_req),
    .pulse_en(u_led_link_if.pulse_en), .disc_mode(u_led_link_if.disc_mode),
    .holdoff_len(u_led_link_if.holdoff_len),
    .photo_comparator_out(u_led_link_if.photo_comparator_out),
    .shunt_state(u_led_link_if.shunt_state), .driver_state(u_led_link_if.driver_state),
    .big_cap_state(u_led_link_if.big_cap_state));

  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic drive_exp(input logic [SEL_W-1:0] c);
    return c[1:0] != 2'b00;
  endfunction : drive_exp

  // One APB transfer, then one idle cycle; read data lands in rd.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rchk

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    comparator_raw = 1'b1;
    hi_code = 12'h000;
    lo_code = 12'h000;
    repeat (8) @(posedge pclk);
    `CHK(shunt_enable_out, 1'b1)
    `CHK(driver_enable_out, 1'b0)
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(ADDR_HOLDOFF, 32'h0000_0064);
    for (i = 0; i < 3; i++) rchk(ADDR_LIMIT0 + 8'(4 * i), 32'h0000_0100);
    rchk(ADDR_EXCESS, 32'h0000_0FFF);
    rchk(ADDR_SELECT, 32'h0000_0010);
    rchk(ADDR_LEVEL, 32'h0000_0003);
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0000_0000);
    done("reset");
    // Every select code in continuous mode with random group thresholds.
    for (i = 0; i < NUM_GROUPS; i++) begin
      seed = lfsr(seed);
      thr[i] = seed[THR_W-1:0];
      apb(1'b1, ADDR_THRESH0 + 8'(4 * i), {22'h0, thr[i]});
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    for (i = 0; i < 16; i++) begin
      code = 4'(i);
      apb(1'b1, ADDR_SELECT, {27'h0, 1'b1, code});
      repeat (4) @(posedge pclk);
      `CHK(driver_enable_out, drive_exp(code))
      `CHK(shunt_enable_out, !drive_exp(code))
      `CHK(big_cap_select_out, 1'b0)
      if (drive_exp(code)) `CHK(photo_dac_code, thr[code[3:2]])
    end
    rchk(ADDR_STATUS, 32'h0000_0000);
    comparator_raw <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(driver_enable_out, 1'b0)
    comparator_raw <= 1'b1;
    repeat (100) @(posedge pclk);
    `CHK(driver_enable_out, 1'b1)
    rchk(ADDR_STATUS, 32'h0000_0001);
    done("decode");
    // Discontinuous pulses: two end on the comparator, the last on the time limit.
    apb(1'b1, ADDR_HOLDOFF, 32'h0000_0028);
    apb(1'b1, ADDR_MASK, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    for (i = 0; i < 3; i++) begin
      if (i == 2) apb(1'b1, ADDR_LIMIT0, 32'h0000_000C);
      apb(1'b1, ADDR_SELECT, 32'h0000_0011);
      apb(1'b1, ADDR_SELECT, 32'h0000_0001);
      `WAITC(shunt_enable_out === 1'b0, 20)
      `WAITC(driver_enable_out === 1'b1, 20)
      `CHK(n, TOGGLE_OFF_CYC)
      `CHK(big_cap_select_out, 1'b1)
      if (i < 2) comparator_raw <= 1'b0;
      `WAITC(shunt_enable_out === 1'b1, 40)
      `CHK(shunt_enable_out, 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(irq, (i < 2))
      rchk(ADDR_STATUS, {31'h0, (i < 2)});
      @(posedge pclk);
      `CHK(irq, 1'b0)
      if (i < 2) begin
        comparator_raw <= 1'b1;
        repeat (3) @(posedge pclk);
        comparator_raw <= 1'b0;
        repeat (3) @(posedge pclk);
        comparator_raw <= 1'b1;
        repeat (50) @(posedge pclk);
        rchk(ADDR_STATUS, 32'h0000_0000);
      end
    end
    done("pulses");
    // Excess check from each amplifier source, masked and unmasked.
    seed = lfsr(seed);
    t = {1'b0, seed[10:0]};
    t1 = t + 12'h001;
    apb(1'b1, ADDR_EXCESS, {20'h0, t});
    for (i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_MASK, {30'h0, i[0], 1'b0});
      apb(1'b1, ADDR_CTRL, {28'h0, 1'b1, i[0], 2'b00});
      {hi_code, lo_code} <= (i == 0) ? {t, t1} : {t1, t};
      repeat (8) @(posedge pclk);
      `CHK(u_led_link_if.excess_flag, 1'b0)
      {hi_code, lo_code} <= (i == 0) ? {t1, t} : {t, t1};
      repeat (8) @(posedge pclk);
      `CHK(u_led_link_if.excess_flag, 1'b1)
      `CHK(irq, i[0])
      rchk(ADDR_STATUS, 32'h0000_0002);
      {hi_code, lo_code} <= {t, t};
      repeat (6) @(posedge pclk);
    end
    done("excess");
    final_report();
  end
endmodule : led_pulse_select_control_tb

// File: tb/led_pulse_sva.sv
// Purpose: Concurrent checks on the link between the controller and the device.
// Assumes: One clock pclk; presetn asynchronous, active low.
// Notes: Instantiated by the bench beside the link interface.
module led_pulse_sva
  import led_pulse_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the controller.
  input wire logic [SEL_W-1:0] led_select_code,
  input wire logic shunt_req,
  input wire logic pulse_en,
  input wire logic disc_mode,
  input wire logic [HOLD_W-1:0] holdoff_len,
  // State reported by the device.
  input wire logic photo_comparator_out,
  input wire logic shunt_state,
  input wire logic driver_state,
  input wire logic big_cap_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  a_off_shunt_high: assert property ((led_select_code == SEL_OFF) [*3] |-> shunt_state)
    else $error("Shunt is not on for the off code.");
  a_off_no_drive: assert property ((led_select_code == SEL_OFF) [*3] |-> !driver_state)
    else $error("Driver runs for the off code.");
  a_blank_shunt: assert property (
    (led_select_code[1:0] == 2'b00 && led_select_code[3:2] != 2'b00) [*3]
    |-> shunt_state && !driver_state)
    else $error("Blanking code does not hold the shunt.");
  a_bigcap_cont: assert property ((!disc_mode) [*3] |-> !big_cap_state)
    else $error("Big capacitor selected in continuous mode.");
  a_bigcap_disc: assert property (disc_mode [*3] |-> big_cap_state)
    else $error("Big capacitor not selected in discontinuous mode.");
  a_holdoff_quiet: assert property (
    $fell(photo_comparator_out) && disc_mode && holdoff_len > 16'h0004
    |=> (!photo_comparator_out) [*3])
    else $error("Comparator edge passed during hold-off.");
  a_fall_ends_pulse: assert property (
    $fell(photo_comparator_out) && disc_mode |-> ##[0:3] shunt_state)
    else $error("Comparator fall did not end the pulse.");
  a_req_fall_pulse: assert property (
    $fell(shunt_req) && disc_mode && pulse_en && led_select_code[1:0] != 2'b00
    |-> ##[1:4] (!shunt_state && !driver_state))
    else $error("Shunt request fall did not start a pulse.");
  a_req_high_shunt: assert property ((shunt_req && disc_mode) [*3] |-> shunt_state)
    else $error("Shunt off while the request is high.");
endmodule : led_pulse_sva
